//--- sar_adc_defines.svh
`ifndef SAR_ADC_DEFINES_SVH
`define SAR_ADC_DEFINES_SVH

// register byte addresses
`define REG_MODE 12'h000
`define REG_CHAN 12'h004
`define REG_ACFG 12'h008
`define REG_STAT 12'h00c
`define REG_DATA 12'h010
`define REG_SAR 12'h014

// mode register fields
`define MODE_EN 0
`define MODE_START 1
`define MODE_IE 2
`define MODE_GIE 3
`define MODE_EXTREF 4
`define MODE_REF_LO 5
`define MODE_REF_HI 6
`define MODE_CK_LO 8
`define MODE_CK_HI 9
`define MODE_SH_LO 10
`define MODE_SH_HI 11
`define MODE_RES_LO 12
`define MODE_RES_HI 13

// channel register fields
`define CHAN_LO 0
`define CHAN_HI 3
`define CHAN_GLOBAL 4

// analog config register: porta bits 4:0, portb bits 15:9 (pins 1..7)
`define ACFG_PA_LO 0
`define ACFG_PA_HI 4
`define ACFG_PB_LO 9
`define ACFG_PB_HI 15

// status register fields
`define STAT_EOC 0
`define STAT_BUSY 1

// channel codes
`define CH_PA_LAST 4'h4
`define CH_PB_LAST 4'hb
`define CH_QUARTER 4'hc

// clock divide select codes
`define CK_DIV16 2'h0
`define CK_DIV8 2'h1
`define CK_DIV1 2'h2
`define CK_DIV2 2'h3

// last divider count per select code
`define DIV16_LAST 4'hf
`define DIV8_LAST 4'h7
`define DIV2_LAST 4'h1
`define DIV1_LAST 4'h0

// resolution select codes
`define RES_8 2'h0
`define RES_10 2'h1

// bits converted per resolution, and the first trial code
`define BITS_8 4'h8
`define BITS_10 4'ha
`define BITS_12 4'hc
`define MSB_TRIAL 12'h800

// the fixed extra conversion clocks beyond sample and bits
`define CONV_OVERHEAD 5'h02

// bias settle time (firmware obligation), in us, and clock in MHz
`define BIAS_SETTLE_US 256
`define MCLK_MHZ 25
`define BIAS_SETTLE_CYC (`BIAS_SETTLE_US * `MCLK_MHZ)

`endif

//--- sar_adc_pkg.sv
package sar_adc_pkg;

typedef enum logic [1:0] {
   ref_2v,
   ref_3v,
   ref_4v,
   ref_supply
} int_ref_t;

typedef struct packed {
   logic [1:0] resolution_field;
   logic [1:0] sample_width_field;
   logic [1:0] conv_clock_divider;
   logic [1:0] int_ref_level;
   logic ext_ref_select;
   logic conv_irq_enable;
   logic conv_enable;
} conv_cfg_t;

typedef struct packed {
   logic ref_external;
   int_ref_t ref_internal;
   logic [4:0] porta_sel;
   logic [7:0] portb_sel;
   logic quarter_sel;
} analog_route_t;

endpackage

//--- conv_clock_gen.sv
`timescale 1ns/1ps
`include "sar_adc_defines.svh"

// one-cycle tick per converter clock period
module conv_clock_gen
(
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic run,
   input wire logic [1:0] conv_clock_divider,
   output logic conv_clock_tick
);

logic [3:0] div_cnt_ff;
logic [3:0] nxt_div_cnt;
logic [3:0] div_last;

assign div_last = (conv_clock_divider == `CK_DIV16) ? `DIV16_LAST :
                  (conv_clock_divider == `CK_DIV8) ? `DIV8_LAST :
                  (conv_clock_divider == `CK_DIV2) ? `DIV2_LAST :
                  `DIV1_LAST;
assign conv_clock_tick = run && (div_cnt_ff >= div_last);
assign nxt_div_cnt = (!run || conv_clock_tick) ? 4'h0 : div_cnt_ff + 4'h1;

always_ff @(posedge mclk or negedge rst_b)
begin
   if (!rst_b)
      div_cnt_ff <= 4'h0;
   else
      div_cnt_ff <= nxt_div_cnt;
end

endmodule // conv_clock_gen

//--- sar_step.sv
`timescale 1ns/1ps

// successive approximation register, one decision per step
module sar_step
#(
   parameter int WIDTH = 12
)
(
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic load,
   input wire logic step,
   input wire logic [WIDTH-1:0] trial_bit,
   input wire logic comp_high,
   output logic [WIDTH-1:0] code
);

logic [WIDTH-1:0] code_ff;
logic [WIDTH-1:0] nxt_code;
genvar i;

// per bit: set the trial bit, clear it again if the comparator says too high
// load parks the msb so the first decision judges a real trial
generate
   for (i = 0; i < WIDTH; i++)
   begin : g_bit
      assign nxt_code[i] = load ? ((i == WIDTH - 1) ? 1'b1 : 1'b0) :
         (step && trial_bit[i]) ? !comp_high :
         (step && (i + 1 < WIDTH) && trial_bit[(i + 1) % WIDTH]) ? 1'b1 :
         code_ff[i];
   end
endgenerate

always_ff @(posedge mclk or negedge rst_b)
begin
   if (!rst_b)
      code_ff <= '0;
   else
      code_ff <= nxt_code;
end

assign code = code_ff;

endmodule // sar_step

//--- sar_adc_control.sv
`timescale 1ns/1ps
`include "sar_adc_defines.svh"
// Operation
// - enable first, then start begins conversion
// - end flag low while converting, high after
// - interrupt on end flag rising, both enables
// - external or internal high reference select
// - no source without global channel select
// - channel code picks pin, quarter supply, none
// - analog config bit makes pin analog only
// - each bit decision on converter clock
// - converter clock divides cpu clock by select
// - sample width 1, 2, 4, 8 converter clocks
// - resolution 8, 10 or 12 bits
// - conversion takes sample plus bits plus two
// - full resolution gives twelve-bit result
module sar_adc_control
(
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic comp_out,
   output logic sample_pulse,
   output logic sar_enable,
   output logic [11:0] dac_code,
   output sar_adc_pkg::analog_route_t route,
   output logic [4:0] porta_analog_cfg,
   output logic [6:0] portb_analog_cfg,
   output logic conv_irq
);

typedef enum logic [1:0] {
   st_idle,
   st_sample,
   st_convert,
   st_tail
} conv_state_t;

conv_state_t state_ff;
conv_state_t nxt_state;
sar_adc_pkg::conv_cfg_t cfg_ff;
logic [4:0] chan_ff;
logic [11:0] acfg_ff;
logic eoc_ff;
logic eoc_d_ff;
logic [11:0] result_ff;
logic [3:0] cnt_ff;
logic [3:0] nxt_cnt;
logic [11:0] trial_ff;
logic [11:0] nxt_trial;
logic gie_ff;
logic prdy_ff;
logic [31:0] rdata_ff;
logic sample_ff;
logic irq_ff;
sar_adc_pkg::analog_route_t route_ff;
logic [4:0] pa_cfg_ff;
logic [6:0] pb_cfg_ff;

wire bus_req = psel && !penable;
// writes land at the access edge, where the master sees pready
wire wr_req = psel && penable && prdy_ff && pwrite;
wire hit_mode = paddr == `REG_MODE;
wire hit_chan = paddr == `REG_CHAN;
wire hit_acfg = paddr == `REG_ACFG;
wire hit_stat = paddr == `REG_STAT;
wire hit_data = paddr == `REG_DATA;
wire hit_any = hit_mode || hit_chan || hit_acfg || hit_stat || hit_data;
wire start_req = wr_req && hit_mode && pwdata[`MODE_START];
wire busy = state_ff != st_idle;
wire tick;
wire [11:0] sar_code;

wire start_ok = start_req && cfg_ff.conv_enable && !busy;

wire [3:0] res_bits = (cfg_ff.resolution_field == `RES_8) ? `BITS_8 :
                      (cfg_ff.resolution_field == `RES_10) ? `BITS_10 :
                      `BITS_12;
wire [3:0] sample_last =
   (4'h1 << cfg_ff.sample_width_field) - 4'h1;
wire [11:0] msb_trial = `MSB_TRIAL;
wire lsb_reached = trial_ff[`BITS_12 - res_bits];
// the last step also raises the trial below the lsb, so mask it off
wire [11:0] res_mask = 12'hfff << (`BITS_12 - res_bits);

conv_clock_gen u_clk
(
   .mclk(mclk),
   .rst_b(rst_b),
   .run(busy),
   .conv_clock_divider(cfg_ff.conv_clock_divider),
   .conv_clock_tick(tick)
);

// the comparator judges our own registered dac_code, so its answer
// settles within the clock and needs no synchroniser
sar_step #(.WIDTH(12)) u_sar
(
   .mclk(mclk),
   .rst_b(rst_b),
   .load(start_ok),
   .step(tick && (state_ff == st_convert)),
   .trial_bit(trial_ff),
   .comp_high(comp_out),
   .code(sar_code)
);

// sample clocks, then one per bit, then two tail clocks
always_comb
begin
   nxt_state = state_ff;
   nxt_cnt = cnt_ff;
   nxt_trial = trial_ff;
   case (state_ff)
      st_idle:
         if (start_ok)
         begin
            nxt_state = st_sample;
            nxt_cnt = 4'h0;
            nxt_trial = msb_trial;
         end
      st_sample:
         if (tick)
         begin
            nxt_cnt = cnt_ff + 4'h1;
            if (cnt_ff == sample_last)
               nxt_state = st_convert;
         end
      st_convert:
         if (tick)
         begin
            nxt_trial = trial_ff >> 1;
            nxt_cnt = 4'h0;
            if (lsb_reached)
               nxt_state = st_tail;
         end
      default:
         if (tick)
         begin
            nxt_cnt = cnt_ff + 4'h1;
            if (cnt_ff == `CONV_OVERHEAD - 5'h01)
               nxt_state = st_idle;
         end
   endcase
end

wire [3:0] ch = chan_ff[`CHAN_HI:`CHAN_LO];
wire gsel = chan_ff[`CHAN_GLOBAL];
wire [4:0] pa_dec = (gsel && ch <= `CH_PA_LAST) ? 5'h01 << ch : 5'h00;
wire [3:0] pb_idx = ch - 4'h4;
wire pb_hit = gsel && ch > `CH_PA_LAST && ch <= `CH_PB_LAST;
wire [7:0] pb_dec = pb_hit ? 8'h01 << pb_idx : 8'h00;

always_ff @(posedge mclk or negedge rst_b)
begin
   if (!rst_b)
   begin
      state_ff <= st_idle;
      cnt_ff <= 4'h0;
      trial_ff <= 12'h000;
   end
   else
   begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      trial_ff <= nxt_trial;
   end
end

// register writes; start is self-clearing and never stored
always_ff @(posedge mclk or negedge rst_b)
begin
   if (!rst_b)
   begin
      cfg_ff <= '0;
      gie_ff <= 1'b0;
      chan_ff <= 5'h00;
      acfg_ff <= 12'h000;
   end
   else if (wr_req && hit_mode)
   begin
      cfg_ff.conv_enable <= pwdata[`MODE_EN];
      cfg_ff.conv_irq_enable <= pwdata[`MODE_IE];
      gie_ff <= pwdata[`MODE_GIE];
      cfg_ff.ext_ref_select <= pwdata[`MODE_EXTREF];
      cfg_ff.int_ref_level <= pwdata[`MODE_REF_HI:`MODE_REF_LO];
      cfg_ff.conv_clock_divider <= pwdata[`MODE_CK_HI:`MODE_CK_LO];
      cfg_ff.sample_width_field <= pwdata[`MODE_SH_HI:`MODE_SH_LO];
      cfg_ff.resolution_field <= pwdata[`MODE_RES_HI:`MODE_RES_LO];
   end
   else if (wr_req && hit_chan)
      chan_ff <= pwdata[`CHAN_GLOBAL:`CHAN_LO];
   else if (wr_req && hit_acfg)
      acfg_ff <= {pwdata[`ACFG_PB_HI:`ACFG_PB_LO],
                  pwdata[`ACFG_PA_HI:`ACFG_PA_LO]};
end

// flag drops at start, rises on completion
always_ff @(posedge mclk or negedge rst_b)
begin
   if (!rst_b)
   begin
      eoc_ff <= 1'b0;
      eoc_d_ff <= 1'b0;
      result_ff <= 12'h000;
   end
   else
   begin
      eoc_d_ff <= eoc_ff;
      if (busy && nxt_state == st_idle)
      begin
         eoc_ff <= 1'b1;
         result_ff <= sar_code & res_mask;
      end
      else if (start_ok)
         eoc_ff <= 1'b0;
   end
end

wire [31:0] mode_word = {18'h00000, cfg_ff.resolution_field,
   cfg_ff.sample_width_field, cfg_ff.conv_clock_divider, 1'b0,
   cfg_ff.int_ref_level, cfg_ff.ext_ref_select, gie_ff,
   cfg_ff.conv_irq_enable, 1'b0, cfg_ff.conv_enable};
wire [31:0] rd_mux =
   hit_mode ? mode_word :
   hit_chan ? {27'h0000000, chan_ff} :
   hit_acfg ? {16'h0000, acfg_ff[11:5], 4'h0, acfg_ff[4:0]} :
   hit_stat ? {30'h00000000, busy, eoc_ff} :
   hit_data ? {20'h00000, result_ff} : 32'h00000000;

// zero-wait-state slave, outputs all registered
always_ff @(posedge mclk or negedge rst_b)
begin
   if (!rst_b)
   begin
      prdy_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      pslverr <= 1'b0;
      sample_ff <= 1'b0;
      irq_ff <= 1'b0;
      route_ff <= '0;
      pa_cfg_ff <= 5'h00;
      pb_cfg_ff <= 7'h00;
   end
   else
   begin
      prdy_ff <= bus_req;
      pslverr <= bus_req && !hit_any;
      if (bus_req)
         rdata_ff <= rd_mux;
      sample_ff <= nxt_state == st_sample;
      irq_ff <= cfg_ff.conv_irq_enable && gie_ff
                && eoc_ff && !eoc_d_ff;
      route_ff.ref_external <= cfg_ff.ext_ref_select;
      route_ff.ref_internal <=
         sar_adc_pkg::int_ref_t'(cfg_ff.int_ref_level);
      route_ff.porta_sel <= pa_dec;
      route_ff.portb_sel <= pb_dec;
      route_ff.quarter_sel <= gsel && ch == `CH_QUARTER;
      pa_cfg_ff <= acfg_ff[4:0];
      pb_cfg_ff <= acfg_ff[11:5];
   end
end

assign prdata = rdata_ff;
assign pready = prdy_ff;
assign sample_pulse = sample_ff;
assign sar_enable = cfg_ff.conv_enable;
assign dac_code = sar_code;
assign route = route_ff;
assign porta_analog_cfg = pa_cfg_ff;
assign portb_analog_cfg = pb_cfg_ff;
assign conv_irq = irq_ff;

// a refused start must not send a running conversion back to sampling
a_busy_no_restart: assert property (@(posedge mclk)
   disable iff (!rst_b)
   busy && start_req |=> (busy || eoc_ff)
   && (state_ff != st_sample || $past(state_ff) == st_sample))
   else $error("start accepted while busy");
a_eoc_low_busy: assert property (@(posedge mclk)
   disable iff (!rst_b)
   busy |-> !eoc_ff) else $error("end flag high while busy");
a_irq_on_rise: assert property (@(posedge mclk)
   disable iff (!rst_b)
   $rose(eoc_ff) && cfg_ff.conv_irq_enable && gie_ff |=> conv_irq)
   else $error("missing interrupt");
a_start_needs_en: assert property (@(posedge mclk)
   disable iff (!rst_b)
   $rose(busy) |-> $past(cfg_ff.conv_enable))
   else $error("conversion without enable");
a_no_route_nogs: assert property (@(posedge mclk)
   disable iff (!rst_b)
   !gsel ##1 !gsel |-> route.porta_sel == 5'h00
   && route.portb_sel == 8'h00 && !route.quarter_sel)
   else $error("source routed without global select");
a_sample_width: assert property (@(posedge mclk)
   disable iff (!rst_b)
   $rose(sample_pulse) && cfg_ff.conv_clock_divider == `CK_DIV1
   && cfg_ff.sample_width_field == 2'h0 |=> !sample_pulse)
   else $error("sample pulse width wrong");
a_conv_bounded: assert property (@(posedge mclk)
   disable iff (!rst_b)
   $rose(busy) |-> ##[1:400] !busy) else $error("conversion hung");
a_analog_cfg: assert property (@(posedge mclk)
   disable iff (!rst_b)
   1'b1 |=> porta_analog_cfg == $past(acfg_ff[4:0])
   && portb_analog_cfg == $past(acfg_ff[11:5]))
   else $error("analog config not applied");
c_conv_done: cover property (@(posedge mclk) $rose(eoc_ff));
c_irq: cover property (@(posedge mclk) conv_irq);
c_busy_start: cover property (@(posedge mclk) busy && start_req);

endmodule // sar_adc_control

//--- sar_adc_analog_src.sv
`timescale 1ns/1ps

// analog sources on the shared pins plus the comparator that judges a trial
module sar_adc_analog_src
(
   input wire logic [11:0] dac_code,
   input wire sar_adc_pkg::analog_route_t route,
   input wire logic [12:0][11:0] levels,
   output logic comp_out
);
   logic [11:0] sel_level;
   logic any_sel;

   // pins are pure inputs with no pulls, so the level is undisturbed
   always_comb
   begin
      sel_level = 12'h000;
      for (int i = 0; i < 5; i++)
         if (route.porta_sel[i]) sel_level = levels[i];
      for (int n = 1; n < 8; n++)
         if (route.portb_sel[n]) sel_level = levels[n+4];
      if (route.quarter_sel) sel_level = levels[12];
   end
   assign any_sel = |{route.porta_sel, route.portb_sel, route.quarter_sel};
   // an open input reads as too high on every trial, so the result is zero
   assign comp_out = any_sel ? (dac_code > sel_level) : 1'b1;
endmodule // sar_adc_analog_src

//--- sar_adc_control_tb_top.sv
`timescale 1ns/1ps

module sar_adc_control_tb_top;
   logic mclk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, comp_out;
   logic [11:0] paddr = 12'h000, dac_code;
   logic [31:0] pwdata = 32'h0, prdata, r;
   logic pready, pslverr, e, sample_pulse, sar_enable, conv_irq;
   sar_adc_pkg::analog_route_t route;
   logic [4:0] pa;
   logic [6:0] pb;
   logic [12:0][11:0] levels = '0;
   logic [16:0] xr;
   int num_errors = 0, samples_checked = 0, cyc = 0, irqs = 0, sp = 0;
   int ck, sh, rs, ch, lv, ie, g, m, bits, dv, ex, d, t0, i0, sp0, x;

   always #20 mclk = ~mclk;

   sar_adc_control DUT (.mclk(mclk), .rst_b(rst_b), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .comp_out(comp_out), .sample_pulse(sample_pulse),
      .sar_enable(sar_enable), .dac_code(dac_code), .route(route),
      .porta_analog_cfg(pa), .portb_analog_cfg(pb), .conv_irq(conv_irq));

   sar_adc_analog_src src (.dac_code(dac_code), .route(route),
      .levels(levels), .comp_out(comp_out));

   task complete_run;
      $display("checks %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   always @(posedge mclk)
   begin
      cyc++;
      if (conv_irq === 1'b1) irqs++;
      if (sample_pulse === 1'b1) sp++;
      if (cyc > 40000)
      begin
         num_errors++;
         complete_run();
      end
   end

   task chk(input string n, input logic [31:0] xp, input logic [31:0] gt);
      samples_checked++;
      if (gt !== xp)
      begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", n, xp, gt);
      end
   endtask

   // one transfer; an idle edge follows so the next setup never collides
   task apb(input logic w, input logic [11:0] a, input logic [31:0] dt);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= dt;
      penable <= 1'b0;
      @(posedge mclk);
      penable <= 1'b1;
      // only the bench timeout ends this wait
      do @(posedge mclk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask

   initial
   begin
      void'($urandom(32'hbb8dd32c));
      repeat (12) @(posedge mclk);
      rst_b <= 1'b1;
      @(posedge mclk);
      apb(0, 12'h00c, 0);
      chk("status_reset", 0, r);
      apb(0, 12'h020, 0);
      chk("unmapped_err", 1, e);
      apb(1, 12'h000, 32'h2);
      apb(0, 12'h00c, 0);
      chk("busy_disabled", 0, r[1]);
      chk("sar_enable_off", 0, sar_enable);
      $display("test reset and refusal done");
      for (int i = 0; i < 32; i++)
      begin
         apb(1, 12'h004, i);
         apb(1, 12'h000, (i & 7) << 4);
         xr = {i[0], i[2:1], 14'h0};
         if (i[4] && i[3:0] < 5) xr[9 + i[3:0]] = 1'b1;
         if (i[4] && i[3:0] > 4 && i[3:0] < 12) xr[i[3:0] - 3] = 1'b1;
         if (i[4] && i[3:0] == 12) xr[0] = 1'b1;
         // route flops load one edge after the write lands
         @(posedge mclk);
         chk("route", xr, route);
      end
      for (int i = 0; i < 3; i++)
      begin
         x = $urandom;
         apb(1, 12'h008, x);
         @(posedge mclk);
         chk("analog_cfg", {x[15:9], x[4:0]}, {pb, pa});
      end
      $display("test routing done");
      apb(1, 12'h000, 1);
      repeat (6400) @(posedge mclk);
      chk("sar_enable_on", 1, sar_enable);
      for (int k = 0; k < 8; k++)
      begin
         ck = k % 4;
         // covers div1 with the shortest sample and both 12-bit codes
         sh = (k + 2 * (k / 4)) % 4;
         rs = k % 4;
         ch = $urandom % 13;
         lv = $urandom % 4096;
         ie = $urandom % 2;
         g = $urandom % 2;
         levels[ch] <= lv[11:0];
         m = 1 | ie << 2 | g << 3 | ck << 8 | sh << 10 | rs << 12;
         apb(1, 12'h004, 16 | ch);
         apb(1, 12'h000, m);
         i0 = irqs;
         sp0 = sp;
         apb(1, 12'h000, m | 2);
         t0 = cyc;
         apb(1, 12'h000, m | 2);
         apb(0, 12'h00c, 0);
         chk("eoc_busy", 2, r[1:0]);
         do apb(0, 12'h00c, 0); while (r[0] !== 1'b1 && cyc - t0 < 2000);
         bits = rs >= 2 ? 12 : (rs == 1 ? 10 : 8);
         dv = ck == 0 ? 16 : (ck == 1 ? 8 : (ck == 2 ? 1 : 2));
         ex = ((1 << sh) + bits + 2) * dv;
         d = cyc - t0 - ex;
         chk("conv_time", 1, d > -(2 * dv + 6) && d < 2 * dv + 10);
         apb(0, 12'h010, 0);
         chk("result", (lv >> (12 - bits)) << (12 - bits), r);
         chk("irq_count", ie & g, irqs - i0);
         d = sp - sp0 - (1 << sh) * dv;
         chk("sample_width", 1, d >= -dv && d <= dv);
         $display("test conversion %0d done", k);
      end
      complete_run();
   end
endmodule // sar_adc_control_tb_top
